/* File: design/wdt_top.v */
`timescale 1ns/1ns
`include "wdt_defs.vh"

module wdt_top (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // Avalon-MM slave
  input  wire [31:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // System outputs
  output reg         wdog_reset_req,
  output wire        wdog_irq
);

  localparam BUS_IDLE = 1'b0;
  localparam BUS_DONE = 1'b1;

  localparam [2:0] SEL_NONE    = 3'h0;
  localparam [2:0] SEL_RELOAD  = 3'h1;
  localparam [2:0] SEL_COUNT   = 3'h2;
  localparam [2:0] SEL_CONTROL = 3'h3;
  localparam [2:0] SEL_SERVICE = 3'h4;
  localparam [2:0] SEL_STATUS  = 3'h5;

  // Bus state
  reg         bus_state_r;
  reg         bus_state_nxt;
  wire        bus_req;
  wire        acc_wr;

  // Registers
  reg  [15:0] reload_r;
  reg  [15:0] count_r;
  reg  [15:0] count_nxt;
  reg  [15:0] control_r;
  reg         lock_r;
  reg  [1:0]  irq_cnt_r;
  reg  [1:0]  irq_cnt_nxt;
  reg  [15:0] read_mux;

  // Decoded accesses
  wire        wr_reload;
  wire        wr_control;
  wire        wr_service;
  wire [15:0] wdata_reload;
  wire [15:0] wdata_control;
  wire [15:0] wdata_service;
  wire        svc_ok;
  wire        svc_bad;
  wire [2:0]  reg_sel;

  // Control fields
  wire        enable;
  wire        periodic_select;
  wire        irq_select;
  wire [1:0]  prescale_sel;
  wire [15:0] restart_value;

  // Timing
  wire        tick;
  wire        count_zero;
  wire        timeout;
  wire [15:0] status_value;

  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  be;
    begin
      lane_merge[7:0]  = be[0] ? wd[7:0]  : old[7:0];
      lane_merge[15:8] = be[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  // One decoder feeds both the write strobes and the read mux
  function [2:0] reg_index;
    input [31:0] addr;
    begin
      if (addr == `WDT_ADDR_RELOAD)
        reg_index = SEL_RELOAD;
      else if (addr == `WDT_ADDR_COUNT)
        reg_index = SEL_COUNT;
      else if (addr == `WDT_ADDR_CONTROL)
        reg_index = SEL_CONTROL;
      else if (addr == `WDT_ADDR_SERVICE)
        reg_index = SEL_SERVICE;
      else if (addr == `WDT_ADDR_STATUS)
        reg_index = SEL_STATUS;
      else
        reg_index = SEL_NONE;
    end
  endfunction

  // ------------------------------------------------------------
  // Avalon-MM slave: every access takes one wait cycle
  // ------------------------------------------------------------
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & (bus_state_r == BUS_IDLE);
  assign acc_wr          = avs_write & (bus_state_r == BUS_DONE);

  always @* begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE: begin
        if (bus_req) begin
          bus_state_nxt = BUS_DONE;
        end
      end
      BUS_DONE: begin
        bus_state_nxt = BUS_IDLE;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  assign reg_sel    = reg_index(avs_address);
  assign wr_reload  = acc_wr & (reg_sel == SEL_RELOAD);
  assign wr_control = acc_wr & (reg_sel == SEL_CONTROL);
  assign wr_service = acc_wr & (reg_sel == SEL_SERVICE);

  assign wdata_reload  = lane_merge(reload_r, avs_writedata,
                                    avs_byteenable);
  assign wdata_control = lane_merge(control_r, avs_writedata,
                                    avs_byteenable);
  // Unwritten service lanes count as zero, so a partial key fails
  assign wdata_service = lane_merge(16'h0000, avs_writedata,
                                    avs_byteenable);

  assign status_value = {11'h000, lock_r, 3'h0, wdog_irq};

  // Reads have no side effects, so data is fetched in the wait cycle
  always @* begin
    if (reg_sel == SEL_RELOAD) begin
      read_mux = reload_r;
    end else if (reg_sel == SEL_COUNT) begin
      read_mux = count_r;
    end else if (reg_sel == SEL_CONTROL) begin
      read_mux = control_r;
    end else if (reg_sel == SEL_STATUS) begin
      read_mux = status_value;
    end else begin
      read_mux = 16'h0000;
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && bus_state_r == BUS_IDLE) begin
      avs_readdata <= {16'h0000, read_mux};
    end
  end

  // ------------------------------------------------------------
  // Configuration registers and lock
  // ------------------------------------------------------------
  assign enable          = control_r[`WDT_CTRL_ENABLE_BIT];
  assign periodic_select = control_r[`WDT_CTRL_PERIODIC_BIT];
  assign irq_select      = control_r[`WDT_CTRL_IRQSEL_BIT];
  assign prescale_sel    = control_r[`WDT_CTRL_PRE_HI:`WDT_CTRL_PRE_LO];

  always @(posedge clock) begin
    if (!rst_b) begin
      control_r <= `WDT_CONTROL_RST;
      lock_r    <= 1'b0;
    end else if (wr_control && !lock_r) begin
      control_r <= (wdata_control & `WDT_CTRL_WMASK) |
                   (`WDT_CONTROL_RST & ~`WDT_CTRL_WMASK);
      lock_r    <= wdata_control[`WDT_CTRL_ENABLE_BIT];
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      reload_r <= `WDT_RELOAD_RST;
    end else if (wr_reload && !lock_r) begin
      reload_r <= wdata_reload;
    end
  end

  // ------------------------------------------------------------
  // Counting
  // ------------------------------------------------------------
  // key check
  assign svc_ok  = wr_service & (wdata_service == `WDT_SERVICE_KEY);
  assign svc_bad = wr_service & (wdata_service != `WDT_SERVICE_KEY);

  assign restart_value = periodic_select ? reload_r : `WDT_FREE_WRAP;

  wdt_prescale wdt_prescale_inst (
    .clock   (clock),
    .rst_b   (rst_b),
    .run     (enable),
    .restart (svc_ok),
    .sel     (prescale_sel),
    .tick    (tick)
  );

  assign count_zero = (count_r == 16'h0000);
  assign timeout    = tick & enable & count_zero;

  always @* begin
    count_nxt = count_r;
    if (svc_ok) begin
      count_nxt = restart_value;
    end else if (tick && enable) begin
      if (count_zero) begin
        count_nxt = restart_value;
      end else begin
        count_nxt = count_r - 16'h0001;
      end
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      count_r <= `WDT_COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ------------------------------------------------------------
  // Timeout actions
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      wdog_reset_req <= 1'b0;
    end else begin
      wdog_reset_req <= (timeout & ~irq_select) | svc_bad;
    end
  end

  // A timeout in the same cycle as a service write still flags
  always @* begin
    irq_cnt_nxt = irq_cnt_r;
    if (timeout && irq_select) begin
      irq_cnt_nxt = `WDT_IRQ_HOLD_CYCLES;
    end else if (svc_ok) begin
      irq_cnt_nxt = 2'h0;
    end else if (irq_cnt_r != 2'h0) begin
      irq_cnt_nxt = irq_cnt_r - 2'h1;
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      irq_cnt_r <= 2'h0;
    end else begin
      irq_cnt_r <= irq_cnt_nxt;
    end
  end

  assign wdog_irq = (irq_cnt_r != 2'h0);

endmodule

/* File: design/wdt_defs.vh */
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// Register byte addresses
`define WDT_ADDR_RELOAD        32'h40002580
`define WDT_ADDR_COUNT         32'h40002584
`define WDT_ADDR_CONTROL       32'h40002588
`define WDT_ADDR_SERVICE       32'h4000258c
`define WDT_ADDR_STATUS        32'h40002598

// Reset values
`define WDT_RELOAD_RST         16'h1000
`define WDT_COUNT_RST          16'h1000
`define WDT_CONTROL_RST        16'h00e9
`define WDT_STATUS_RST         16'h0000

// Writable control bits; the others keep their reset value
`define WDT_CTRL_WMASK         16'h006f

// Control field positions
`define WDT_CTRL_PERIODIC_BIT  6
`define WDT_CTRL_ENABLE_BIT    5
`define WDT_CTRL_PRE_HI        3
`define WDT_CTRL_PRE_LO        2
`define WDT_CTRL_IRQSEL_BIT    1
`define WDT_CTRL_HIBER_BIT     0

// Status field positions
`define WDT_STAT_LOCK_BIT      4
`define WDT_STAT_IRQ_BIT       0

// Service key and free-running wrap value
`define WDT_SERVICE_KEY        16'hcccc
`define WDT_FREE_WRAP          16'h1000

// Prescaler codes and terminal counts
`define WDT_PRE_DIV1           2'h0
`define WDT_PRE_DIV16          2'h1
`define WDT_PRE_DIV256         2'h2
`define WDT_PRE_DIV4096        2'h3
`define WDT_DIV1_LAST          12'h000
`define WDT_DIV16_LAST         12'h00f
`define WDT_DIV256_LAST        12'h0ff
`define WDT_DIV4096_LAST       12'hfff

// Timing: system clock and low-frequency oscillator periods
`define WDT_CLK_PERIOD_NS      40
`define WDT_LOW_FREQ_INTERNAL_OSC_PERIOD_NS    30518
`define WDT_LOW_FREQ_INTERNAL_OSC_CYCLES       (`WDT_LOW_FREQ_INTERNAL_OSC_PERIOD_NS / `WDT_CLK_PERIOD_NS)

// Interrupt flag lifetime in clock cycles
`define WDT_IRQ_HOLD_CYCLES    2'h2

`endif

/* File: design/wdt_prescale.v */
`timescale 1ns/1ns
`include "wdt_defs.vh"

module wdt_prescale (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // Control
  input  wire       run,
  input  wire       restart,
  input  wire [1:0] sel,
  // Count enable
  output reg        tick
);

  localparam integer LF_LAST = `WDT_LOW_FREQ_INTERNAL_OSC_CYCLES - 1;

  reg  [9:0]  lf_cnt_r;
  reg  [11:0] pre_cnt_r;
  wire        lf_tick;
  wire        pre_done;

  function [11:0] div_last;
    input [1:0] code;
    begin
      if (code == `WDT_PRE_DIV1)
        div_last = `WDT_DIV1_LAST;
      else if (code == `WDT_PRE_DIV16)
        div_last = `WDT_DIV16_LAST;
      else if (code == `WDT_PRE_DIV256)
        div_last = `WDT_DIV256_LAST;
      else
        div_last = `WDT_DIV4096_LAST;
    end
  endfunction

  // Stand-in for the low-frequency oscillator: one enable per period
  assign lf_tick  = (lf_cnt_r == LF_LAST[9:0]);
  // Shrinking the divider mid-count must not strand the counter above it
  assign pre_done = (pre_cnt_r >= div_last(sel));

  always @(posedge clock) begin
    if (!rst_b || !run || restart) begin
      lf_cnt_r <= 10'h000;
    end else if (lf_tick) begin
      lf_cnt_r <= 10'h000;
    end else begin
      lf_cnt_r <= lf_cnt_r + 10'h001;
    end
  end

  always @(posedge clock) begin
    if (!rst_b || !run || restart) begin
      pre_cnt_r <= 12'h000;
      tick      <= 1'b0;
    end else if (lf_tick) begin
      tick      <= pre_done;
      pre_cnt_r <= pre_done ? 12'h000 : pre_cnt_r + 12'h001;
    end else begin
      tick      <= 1'b0;
    end
  end

endmodule

/* File: verif/wdt_chk_sva.sv */
`timescale 1ns/1ns
`include "wdt_defs.vh"
module wdt_chk (
  // Clock and reset
  input wire        clock,
  input wire        rst_b,
  // Register bus
  input wire [31:0] avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // System outputs
  input wire        wdog_reset_req,
  input wire        wdog_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence new_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence bad_key;
    avs_write && !avs_waitrequest && avs_address == `WDT_ADDR_SERVICE
      && avs_byteenable[1:0] == 2'h3
      && avs_writedata[15:0] != `WDT_SERVICE_KEY;
  endsequence
  one_wait_a: assert property (new_req |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("wait cycle count wrong");
  idle_wait_a: assert property (!(avs_read || avs_write) |->
    !avs_waitrequest) else $error("waitrequest while idle");
  upper_zero_a: assert property (avs_readdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  rd_hold_a: assert property (avs_read && !avs_waitrequest |=>
    $stable(avs_readdata)) else $error("read data changed");
  bad_key_a: assert property (bad_key |=> wdog_reset_req)
    else $error("bad service key gave no reset");
  reset_pulse_a: assert property (wdog_reset_req |=> !wdog_reset_req)
    else $error("reset request longer than one cycle");
  irq_min_a: assert property ($rose(wdog_irq) && !avs_write |=>
    wdog_irq) else $error("interrupt flag too short");
  irq_max_a: assert property (wdog_irq [*2] |=> !wdog_irq)
    else $error("interrupt flag too long");
endmodule

/* File: verif/wdt_top_bench.sv */
`timescale 1ns/1ns
`include "wdt_defs.vh"
module wdt_top_bench;
  logic        clock;
  logic        rst_b;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_address;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         wdog_reset_req;
  wire         wdog_irq;
  integer      error_cnt = 0;
  integer      compares = 0;
  integer      cyc_cnt = 0;
  integer      seed = 32'h89b7;
  integer      n;
  integer      i;
  logic [15:0] rnd;
  logic [31:0] exp_q[$];

  wdt_top wdt_top_inst (.clock(clock), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wdog_reset_req(wdog_reset_req),
    .wdog_irq(wdog_irq));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task check(input logic [31:0] seen, input logic [31:0] want);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask

  task conclude;
    begin
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task bus(input logic is_rd, input logic [31:0] a, input logic [31:0] d);
    begin
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= is_rd;
      avs_write <= !is_rd;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task rd(input logic [31:0] a, input logic [31:0] want);
    begin
      exp_q.push_back(want);
      bus(1'b1, a, 32'h0);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  // Cycles from the end of the last access until the output rises
  task wait_evt(input logic use_irq, input integer lo, input integer hi);
    begin
      n = 0;
      while ((use_irq ? wdog_irq : wdog_reset_req) !== 1'b1 && n <= hi) begin
        @(negedge clock);
        n = n + 1;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
    end
  endtask

  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0)
      check(avs_readdata, exp_q.pop_front());
  end

  always @(posedge clock) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 8000) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t: timeout", $time);
      conclude;
    end
  end

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 32'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(`WDT_ADDR_RELOAD, 32'h1000);
    rd(`WDT_ADDR_COUNT, 32'h1000);
    rd(`WDT_ADDR_CONTROL, 32'h00e9);
    rd(`WDT_ADDR_STATUS, 32'h0);
    rd(32'h40002590, 32'h0);
    wr(`WDT_ADDR_COUNT, 32'h0);
    rd(`WDT_ADDR_COUNT, 32'h1000);
    $display("reset values done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(`WDT_ADDR_CONTROL, {28'h0, i[1:0], 2'h0});
      rd(`WDT_ADDR_CONTROL, {28'h8, i[1:0], 2'h0});
    end
    rd(`WDT_ADDR_STATUS, 32'h0);
    rnd = $random(seed);
    wr(`WDT_ADDR_RELOAD, {16'h0, rnd});
    rd(`WDT_ADDR_RELOAD, {16'h0, rnd});
    wr(`WDT_ADDR_CONTROL, 32'h40);
    wr(`WDT_ADDR_SERVICE, {16'h0, `WDT_SERVICE_KEY});
    rd(`WDT_ADDR_COUNT, {16'h0, rnd});
    wr(`WDT_ADDR_CONTROL, 32'h0);
    wr(`WDT_ADDR_SERVICE, {16'h0, `WDT_SERVICE_KEY});
    rd(`WDT_ADDR_COUNT, 32'h1000);
    wr(`WDT_ADDR_RELOAD, 32'h1);
    wr(`WDT_ADDR_CONTROL, 32'h62);
    rd(`WDT_ADDR_CONTROL, 32'he2);
    rd(`WDT_ADDR_STATUS, 32'h10);
    wr(`WDT_ADDR_RELOAD, 32'h55);
    wr(`WDT_ADDR_CONTROL, 32'h0);
    rd(`WDT_ADDR_RELOAD, 32'h1);
    rd(`WDT_ADDR_CONTROL, 32'he2);
    $display("lock done");
    wr(`WDT_ADDR_SERVICE, {16'h0, `WDT_SERVICE_KEY});
    // The pin is watched; the short-lived status flag is never polled
    wait_evt(1'b1, 1515, 1535);
    check({31'h0, wdog_reset_req}, 32'h0);
    rnd = $random(seed);
    if (rnd == `WDT_SERVICE_KEY) rnd = 16'h0;
    wr(`WDT_ADDR_SERVICE, {16'h0, rnd});
    wait_evt(1'b0, 1, 3);
    $display("interrupt mode done");
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(`WDT_ADDR_STATUS, 32'h0);
    rd(`WDT_ADDR_CONTROL, 32'h00e9);
    wr(`WDT_ADDR_RELOAD, 32'h0);
    wr(`WDT_ADDR_CONTROL, 32'h60);
    wr(`WDT_ADDR_SERVICE, {16'h0, `WDT_SERVICE_KEY});
    wait_evt(1'b0, 755, 770);
    $display("reset mode done");
    conclude;
  end
endmodule

bind wdt_top wdt_chk wdt_chk_inst (.clock(clock), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .wdog_reset_req(wdog_reset_req),
  .wdog_irq(wdog_irq));
